// file: hdl/msq_defines.vh
`ifndef MSQ_DEFINES_VH
`define MSQ_DEFINES_VH
// Command opcodes on the decoded command port.
`define MSQ_OP_JOG_HALT 4'h0
`define MSQ_OP_HALT_FLUSH 4'h1
`define MSQ_OP_MOVE_HALT 4'h2
`define MSQ_OP_OUTPUT_DRIVE 4'h3
`define MSQ_OP_POS_PRESET 4'h4
`define MSQ_OP_STRING_REPLY 4'h5
`define MSQ_OP_CURRENT_HALT 4'h6
`define MSQ_OP_JOG_ACCEL 4'h7
`define MSQ_OP_JOG_DECEL 4'h8
`define MSQ_OP_MOTION 4'h9
`define MSQ_OP_WAIT 4'ha
// Parameter letter codes.
`define MSQ_LET_NONE 2'h0
`define MSQ_LET_D 2'h1
`define MSQ_LET_M 2'h2
// Output levels: L drives low (closed), H drives high (open).
`define MSQ_LET_L 2'h1
`define MSQ_LET_H 2'h2
// Motion kinds.
`define MSQ_MOVE_FEED 2'h1
`define MSQ_MOVE_JOG 2'h2
`define MSQ_MOVE_HOME 2'h3
// Deceleration source select.
`define MSQ_DSEL_MAX 2'h0
`define MSQ_DSEL_DECEL 2'h1
`define MSQ_DSEL_JOG 2'h2
// Payload field positions.
`define MSQ_OUT_MAIN_BIT 8
`define MSQ_OUT_IDX_MSB 3
`define MSQ_STR_LEN_LSB 32
`define MSQ_STR_LEN_MSB 34
`define MSQ_STR_MAX_LEN 3'h4
// Reset values.
`define MSQ_OUT_RESET 8'hff
`define MSQ_MAIN_RESET 4'hf
`endif

// file: hdl/msq_queue_mem.v
`timescale 1ns/1ps
// Simple single-port-read queue storage with registered read data.
module msq_queue_mem #(
  parameter WIDTH = 44,
  parameter AW = 3
) (
  // Clock.
  input wire clock_i,
  // Write side.
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [WIDTH-1:0] wr_data_i,
  // Read side.
  input wire [AW-1:0] rd_addr_i,
  output reg [WIDTH-1:0] rd_data_o
);
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  // Storage needs no reset; the queue pointers guard its contents.
  always @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule // msq_queue_mem

// file: hdl/msq_stop_queue.v
`timescale 1ns/1ps
`include "msq_defines.vh"
module msq_stop_queue #(
  parameter AW = 3,
  parameter RW = 32
) (
  // Clock and reset.
  input wire clock_i,
  input wire rst_n_i,
  // Decoded command from the link parser.
  input wire cmd_valid_i,
  input wire [3:0] cmd_op_i,
  input wire cmd_immediate_i,
  input wire [1:0] cmd_letter_i,
  input wire cmd_has_value_i,
  input wire [43:0] cmd_payload_i,
  output reg cmd_ready_o,
  // Configuration.
  input wire multitask_enable_i,
  input wire multidrop_link_i,
  input wire [3:0] main_out_general_i,
  input wire [RW-1:0] max_accel_setting_i,
  input wire [RW-1:0] decel_setting_i,
  // Motion engine handshake.
  input wire motion_busy_i,
  input wire [1:0] motion_kind_i,
  input wire wait_busy_i,
  output reg motion_start_o,
  output reg [43:0] motion_param_o,
  output reg motion_stop_o,
  output reg wait_abort_o,
  output reg [RW-1:0] stop_decel_o,
  output reg [1:0] stop_decel_sel_o,
  // Outputs.
  output reg [7:0] exp_out_o,
  output reg [3:0] main_out_o,
  // Position counter.
  input wire [RW-1:0] position_i,
  output reg pos_load_o,
  output reg [RW-1:0] pos_value_o,
  output reg pos_report_o,
  // Reply string to the transmitter.
  output reg reply_valid_o,
  output reg [31:0] reply_data_o,
  output reg [2:0] reply_len_o,
  input wire reply_ready_i,
  // Status.
  output reg [RW-1:0] jog_accel_o,
  output reg [RW-1:0] jog_decel_o,
  output reg [AW:0] queue_count_o
);
  localparam DEPTH = 1 << AW;
  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_EXEC = 2'h2;
  localparam ST_RUN = 2'h3;

  // **********************************************
  // Queue pointers and storage
  // **********************************************
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  reg [1:0] st_q;
  reg flush_q;
  wire [43:0] rd_word;
  wire [3:0] q_op = rd_word[43:40];

  // Each entry holds opcode, letter, has-value flag and payload.
  wire push_ok = cmd_valid_i && !cmd_immediate_i && (cnt_q != DEPTH[AW:0]);
  wire q_wr = push_ok && !(cmd_op_i == `MSQ_OP_HALT_FLUSH);
  // Only payload bits 39:0 are stored; the opcode takes the top nibble of an entry.
  wire [43:0] q_word = {cmd_op_i, cmd_payload_i[39:0]};
  reg [1:0] q_let [0:DEPTH-1];
  reg q_val [0:DEPTH-1];

  msq_queue_mem #(.WIDTH(44), .AW(AW)) u_mem (
    .clock_i(clock_i),
    .wr_en_i(q_wr),
    .wr_addr_i(wr_q),
    .wr_data_i(q_word),
    .rd_addr_i(rd_q),
    .rd_data_o(rd_word)
  );

  // Letter and value flags stay beside the memory; they are small.
  always @(posedge clock_i) begin
    if (q_wr) begin
      q_let[wr_q] <= cmd_letter_i;
      q_val[wr_q] <= cmd_has_value_i;
    end
  end

  // **********************************************
  // Deceleration rate selection
  // **********************************************
  // Choose the deceleration source for a stop.
  function [1:0] decel_src;
    input [1:0] letter;
    input [1:0] kind;
    input move_halt;
    begin
      if (letter == `MSQ_LET_D) begin
        decel_src = (kind == `MSQ_MOVE_JOG) ? `MSQ_DSEL_JOG : `MSQ_DSEL_DECEL;
      end else if (move_halt && letter != `MSQ_LET_M) begin
        decel_src = `MSQ_DSEL_MAX;
      end else begin
        decel_src = `MSQ_DSEL_MAX;
      end
    end
  endfunction

  reg [RW-1:0] ja_q;
  reg [RW-1:0] jl_q;

  // Map a source select to the rate value.
  function [RW-1:0] decel_val;
    input [1:0] sel;
    input [RW-1:0] mx;
    input [RW-1:0] de;
    input [RW-1:0] jl;
    begin
      case (sel)
        `MSQ_DSEL_DECEL: decel_val = de;
        `MSQ_DSEL_JOG: decel_val = jl;
        default: decel_val = mx;
      endcase
    end
  endfunction

  // **********************************************
  // Shared decode
  // **********************************************
  wire imm = cmd_valid_i && cmd_immediate_i;
  wire [1:0] hf_sel = decel_src(cmd_letter_i, motion_kind_i, 1'b0);
  wire [1:0] e_let = q_let[rd_q];
  wire e_val = q_val[rd_q];
  wire [1:0] mh_sel = decel_src(e_let, motion_kind_i, 1'b1);
  wire [AW:0] pop_cnt = cnt_q - {{AW{1'b0}}, 1'b1};
  wire [AW:0] push_cnt = cnt_q + {{AW{1'b0}}, 1'b1};

  // **********************************************
  // Sequencer
  // **********************************************
  // One state machine both drains the queue and applies immediate halts.
  // Immediate commands are served in the same cycle they arrive.
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      // Every output returns to its idle level and the queue is empty.
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      st_q <= ST_IDLE;
      flush_q <= 1'b0;
      ja_q <= {RW{1'b0}};
      jl_q <= {RW{1'b0}};
      cmd_ready_o <= 1'b0;
      motion_start_o <= 1'b0;
      motion_param_o <= 44'h0;
      motion_stop_o <= 1'b0;
      wait_abort_o <= 1'b0;
      stop_decel_o <= {RW{1'b0}};
      stop_decel_sel_o <= `MSQ_DSEL_MAX;
      exp_out_o <= `MSQ_OUT_RESET;
      main_out_o <= `MSQ_MAIN_RESET;
      pos_load_o <= 1'b0;
      pos_value_o <= {RW{1'b0}};
      pos_report_o <= 1'b0;
      reply_valid_o <= 1'b0;
      reply_data_o <= 32'h0;
      reply_len_o <= 3'h0;
      jog_accel_o <= {RW{1'b0}};
      jog_decel_o <= {RW{1'b0}};
      queue_count_o <= {(AW+1){1'b0}};
    end else begin
      motion_start_o <= 1'b0;
      motion_stop_o <= 1'b0;
      wait_abort_o <= 1'b0;
      pos_load_o <= 1'b0;
      pos_report_o <= 1'b0;
      // Ready is a cycle late, so it drops one entry early to leave room
      // for a command that is already on its way.
      cmd_ready_o <= (cnt_q < DEPTH[AW:0] - {{AW{1'b0}}, 1'b1});
      if (reply_valid_o && reply_ready_i) begin
        reply_valid_o <= 1'b0;
      end
      // Buffered commands are appended in arrival order.
      if (q_wr) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      // A jog halt outside jogging is a no-op.
      if (imm && cmd_op_i == `MSQ_OP_JOG_HALT) begin
        if (motion_busy_i && motion_kind_i == `MSQ_MOVE_JOG) begin
          motion_stop_o <= 1'b1;
          stop_decel_sel_o <= `MSQ_DSEL_JOG;
          stop_decel_o <= jl_q;
        end
      end
      if (imm && (cmd_op_i == `MSQ_OP_HALT_FLUSH || cmd_op_i == `MSQ_OP_CURRENT_HALT)) begin
        // Abort the executing command only; queue kept for current halt.
        motion_stop_o <= motion_busy_i;
        wait_abort_o <= wait_busy_i;
        // Plain uses max accel, D uses decel or jog decel.
        stop_decel_sel_o <= hf_sel;
        stop_decel_o <= decel_val(hf_sel, max_accel_setting_i, decel_setting_i, jl_q);
        if (st_q == ST_RUN) begin
          st_q <= ST_IDLE;
        end
      end
      if (imm && cmd_op_i == `MSQ_OP_HALT_FLUSH) begin
        // Discard every waiting entry; later pushes this cycle are dropped.
        // Moving the read pointer onto the write pointer empties the queue at once.
        rd_q <= wr_q;
        cnt_q <= {(AW+1){1'b0}};
        flush_q <= 1'b1;
        st_q <= ST_IDLE;
      end else begin
        flush_q <= 1'b0;
        case (st_q)
          ST_IDLE: begin
            // A pending reply holds the next entry back, so that a later string
            // reply can never overwrite one the transmitter has not taken.
            if (cnt_q != {(AW+1){1'b0}} && !reply_valid_o) begin
              st_q <= ST_READ;
            end
            if (q_wr) begin
              cnt_q <= push_cnt;
            end
          end
          ST_READ: begin
            // The registered memory read needs this cycle.
            st_q <= ST_EXEC;
            if (q_wr) begin
              cnt_q <= push_cnt;
            end
          end
          ST_EXEC: begin
            // Each entry leaves the queue as it executes, unless a flush discards it first.
            st_q <= ST_IDLE;
            rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
            cnt_q <= q_wr ? cnt_q : pop_cnt;
            case (q_op)
              `MSQ_OP_MOVE_HALT: begin
                // Seek home survives; waits keep running; queue intact.
                if (motion_busy_i && motion_kind_i != `MSQ_MOVE_HOME) begin
                  motion_stop_o <= 1'b1;
                  stop_decel_sel_o <= mh_sel;
                  stop_decel_o <= decel_val(mh_sel, max_accel_setting_i,
                                            decel_setting_i, jl_q);
                end
              end
              `MSQ_OP_OUTPUT_DRIVE: begin
                if (rd_word[`MSQ_OUT_MAIN_BIT]) begin
                  // Main-board outputs move only once made general.
                  if (main_out_general_i[rd_word[1:0]]) begin
                    main_out_o[rd_word[1:0]] <= (e_let == `MSQ_LET_H);
                  end
                end else begin
                  exp_out_o[rd_word[2:0]] <= (e_let == `MSQ_LET_H);
                end
              end
              `MSQ_OP_POS_PRESET: begin
                // Signed value loads; without a value the position is reported.
                if (e_val) begin
                  pos_load_o <= 1'b1;
                  pos_value_o <= rd_word[RW-1:0];
                end else begin
                  pos_report_o <= 1'b1;
                  pos_value_o <= position_i;
                end
              end
              `MSQ_OP_STRING_REPLY: begin
                // Silent on a multidrop link.
                if (!multidrop_link_i) begin
                  reply_valid_o <= 1'b1;
                  reply_data_o <= rd_word[31:0];
                  reply_len_o <= (rd_word[`MSQ_STR_LEN_MSB:`MSQ_STR_LEN_LSB] >
                                  `MSQ_STR_MAX_LEN) ? `MSQ_STR_MAX_LEN :
                                  rd_word[`MSQ_STR_LEN_MSB:`MSQ_STR_LEN_LSB];
                end
              end
              `MSQ_OP_JOG_ACCEL: begin
                ja_q <= rd_word[RW-1:0];
                jl_q <= rd_word[RW-1:0];
              end
              `MSQ_OP_JOG_DECEL: begin
                jl_q <= rd_word[RW-1:0];
              end
              `MSQ_OP_MOTION: begin
                motion_start_o <= 1'b1;
                motion_param_o <= rd_word;
                // Single tasking holds the queue until the move ends.
                if (!multitask_enable_i) begin
                  st_q <= ST_RUN;
                end
              end
              default: begin
              end
            endcase
          end
          ST_RUN: begin
            // The start pulse still stands in the first cycle here, before busy rises.
            if (!motion_busy_i && !motion_start_o) begin
              st_q <= ST_IDLE;
            end
            if (q_wr) begin
              cnt_q <= push_cnt;
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
      // Status copies are registered so every output comes from a flop;
      // the queue count therefore lags the pointers by one cycle.
      jog_accel_o <= ja_q;
      jog_decel_o <= jl_q;
      queue_count_o <= cnt_q;
    end
  end
endmodule // msq_stop_queue

// file: test/msq_stop_queue_properties.sv
`timescale 1ns/1ps
`include "msq_defines.vh"
// ****************************
// Stop and queue port checks
// ****************************
module msq_stop_queue_chk #(
  parameter AW = 3,
  parameter RW = 32
) (
  // Watched inputs.
  input wire clock_i,
  input wire rst_n_i,
  input wire cmd_valid_i,
  input wire cmd_immediate_i,
  input wire [3:0] cmd_op_i,
  input wire [1:0] cmd_letter_i,
  input wire multidrop_link_i,
  input wire [RW-1:0] max_accel_setting_i,
  input wire motion_busy_i,
  input wire [1:0] motion_kind_i,
  input wire wait_busy_i,
  input wire reply_ready_i,
  // Watched outputs.
  input wire motion_stop_o,
  input wire wait_abort_o,
  input wire [RW-1:0] stop_decel_o,
  input wire [1:0] stop_decel_sel_o,
  input wire [7:0] exp_out_o,
  input wire [RW-1:0] jog_accel_o,
  input wire [RW-1:0] jog_decel_o,
  input wire reply_valid_o,
  input wire [31:0] reply_data_o,
  input wire [AW:0] queue_count_o
);
  // Immediate commands that land while a move runs, and the two halts that share rates.
  wire hit = cmd_valid_i && cmd_immediate_i && motion_busy_i;
  wire halt = cmd_op_i == `MSQ_OP_HALT_FLUSH || cmd_op_i == `MSQ_OP_CURRENT_HALT;
  reg imm_q;
  // Waits may only be cut by an immediate command, so remember the last one.
  always @(posedge clock_i) begin
    imm_q <= cmd_valid_i && cmd_immediate_i;
  end
  default clocking dc @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  chk_reset_level:
    assert property (disable iff (1'b0) !rst_n_i |=> exp_out_o == 8'hff)
    else $error("expansion outputs not high after reset");
  chk_jog_halt:
    assert property (hit && cmd_op_i == `MSQ_OP_JOG_HALT && motion_kind_i == `MSQ_MOVE_JOG
      |=> motion_stop_o && stop_decel_sel_o == `MSQ_DSEL_JOG && stop_decel_o == jog_decel_o)
    else $error("jog halt rate wrong");
  chk_plain_rate:
    assert property (hit && halt && cmd_letter_i == `MSQ_LET_NONE |=> motion_stop_o
      && stop_decel_sel_o == `MSQ_DSEL_MAX && stop_decel_o == $past(max_accel_setting_i))
    else $error("plain halt rate wrong");
  chk_d_rate:
    assert property (hit && halt && cmd_letter_i == `MSQ_LET_D |=> stop_decel_sel_o ==
      ($past(motion_kind_i) == `MSQ_MOVE_JOG ? `MSQ_DSEL_JOG : `MSQ_DSEL_DECEL))
    else $error("halt with D rate wrong");
  chk_flush_empty:
    assert property (cmd_valid_i && cmd_immediate_i && cmd_op_i == `MSQ_OP_HALT_FLUSH
      ##1 !cmd_valid_i |=> queue_count_o == 0)
    else $error("queue not emptied by flush");
  chk_current_abort:
    assert property (cmd_valid_i && cmd_immediate_i && cmd_op_i == `MSQ_OP_CURRENT_HALT
      && wait_busy_i |=> wait_abort_o)
    else $error("wait not aborted by current halt");
  chk_wait_kept:
    assert property (wait_abort_o |-> imm_q)
    else $error("wait aborted without immediate halt");
  chk_reply_hold:
    assert property (reply_valid_o && !reply_ready_i |=> reply_valid_o && $stable(reply_data_o))
    else $error("reply dropped before accept");
  chk_multidrop_quiet:
    assert property (multidrop_link_i [*4] |=> !$rose(reply_valid_o))
    else $error("reply on multidrop link");
  chk_jog_pair:
    assert property ($changed(jog_accel_o) |-> jog_decel_o == jog_accel_o)
    else $error("jog decel not following jog accel");
endmodule // msq_stop_queue_chk

bind msq_stop_queue msq_stop_queue_chk #(.AW(AW), .RW(RW)) u_chk (.*);

// file: test/msq_engine_model.sv
`timescale 1ns/1ps
// ****************************
// Motion engine and receiver
// ****************************
module msq_engine_model (
  // Clock and reset.
  input wire clock_i,
  input wire rst_n_i,
  // From the design.
  input wire motion_start_i,
  input wire motion_stop_i,
  input wire wait_abort_i,
  input wire reply_valid_i,
  // Bench controls.
  input wire [1:0] kind_i,
  input wire [7:0] span_i,
  input wire wait_go_i,
  // Toward the design.
  output reg motion_busy_o,
  output reg [1:0] motion_kind_o,
  output reg wait_busy_o,
  output reg reply_ready_o
);
  reg [7:0] left_q;
  reg [1:0] lag_q;
  // A move stays busy for span plus one cycles unless stopped; the reply lag follows the span bits.
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      motion_busy_o <= 1'b0;
      motion_kind_o <= 2'h0;
      wait_busy_o <= 1'b0;
      reply_ready_o <= 1'b0;
      left_q <= 8'h0;
      lag_q <= 2'h0;
    end else begin
      if (motion_start_i) begin
        motion_busy_o <= 1'b1;
        motion_kind_o <= kind_i;
        left_q <= span_i;
      end else if (motion_stop_i || left_q == 8'h0) begin
        motion_busy_o <= 1'b0;
        motion_kind_o <= 2'h0;
      end else begin
        left_q <= left_q - 8'h1;
      end
      wait_busy_o <= wait_go_i || (wait_busy_o && !wait_abort_i);
      reply_ready_o <= reply_valid_i && !reply_ready_o && lag_q == span_i[1:0];
      lag_q <= (reply_valid_i && !reply_ready_o) ? lag_q + 2'h1 : 2'h0;
    end
  end
endmodule // msq_engine_model

// file: test/msq_stop_queue_bench.sv
`timescale 1ns/1ps
`include "msq_defines.vh"
// ****************************
// Stop and queue bench
// ****************************
module msq_stop_queue_bench;
  reg clock_i = 1'b0, rst_n_i = 1'b0, cmd_valid_i = 1'b0, cmd_immediate_i = 1'b0;
  reg cmd_has_value_i = 1'b0, multitask_enable_i = 1'b0, multidrop_link_i = 1'b0;
  reg wait_go = 1'b0, keep = 1'b1;
  reg [3:0] cmd_op_i = 4'h0, main_out_general_i = 4'hf, mo;
  reg [1:0] cmd_letter_i = 2'h0, kind_q = 2'h2;
  reg [7:0] span_q = 8'h40, eo;
  reg [43:0] cmd_payload_i = 44'h0;
  reg [31:0] max_accel_setting_i = 32'h0, decel_setting_i = 32'h0, position_i = 32'h0, v, jd;
  reg [9:0] t;
  reg [69:0] tab = {10'h00a, 10'h044, 10'h055, 10'h05a, 10'h188, 10'h195, 10'h19a};
  reg [34:0] exp_rep[$];
  reg [31:0] exp_pos[$];
  integer error_cnt = 0, n_compared = 0, stops = 0, reports = 0, i, j, s0;
  wire cmd_ready_o, motion_start_o, motion_stop_o, wait_abort_o, pos_load_o, pos_report_o;
  wire reply_valid_o, motion_busy_i, wait_busy_i, reply_ready_i;
  wire [1:0] motion_kind_i, stop_decel_sel_o;
  wire [2:0] reply_len_o;
  wire [3:0] main_out_o, queue_count_o;
  wire [7:0] exp_out_o;
  wire [31:0] stop_decel_o, pos_value_o, reply_data_o, jog_accel_o, jog_decel_o;
  wire [43:0] motion_param_o;
  msq_stop_queue u_dut (.*);
  msq_engine_model u_eng (.clock_i(clock_i), .rst_n_i(rst_n_i), .motion_start_i(motion_start_o),
    .motion_stop_i(motion_stop_o), .wait_abort_i(wait_abort_o), .reply_valid_i(reply_valid_o),
    .kind_i(kind_q), .span_i(span_q), .wait_go_i(wait_go), .motion_busy_o(motion_busy_i),
    .motion_kind_o(motion_kind_i), .wait_busy_o(wait_busy_i), .reply_ready_o(reply_ready_i));
  // Free running 100 MHz clock.
  initial forever #5 clock_i = ~clock_i;
  task chk(input [63:0] exp, input [63:0] got, input [8*12-1:0] what);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  // One command held for one edge; the model expects a reply only where one may come.
  task send(input [3:0] op, input imm, input [1:0] lt, input hv, input [43:0] pl);
    begin
      @(negedge clock_i);
      cmd_op_i = op;
      cmd_immediate_i = imm;
      cmd_letter_i = lt;
      cmd_has_value_i = hv;
      cmd_payload_i = pl;
      cmd_valid_i = 1'b1;
      if (op == `MSQ_OP_STRING_REPLY && keep && !multidrop_link_i) exp_rep.push_back(pl[34:0]);
      @(negedge clock_i);
      cmd_valid_i = 1'b0;
      cmd_payload_i = ~pl;
    end
  endtask
  task idle(input integer n);
    repeat (n) @(negedge clock_i);
  endtask
  task drain;
    begin
      for (i = 0; i < 300 && exp_rep.size() > 0; i = i + 1) @(negedge clock_i);
      chk(0, exp_rep.size(), "replies left");
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // Result monitor: replies and presets are matched in order against the model queues.
  always @(posedge clock_i) begin
    if (reply_valid_o && reply_ready_i)
      chk(exp_rep.size() ? exp_rep.pop_front() : 35'hx, {reply_len_o, reply_data_o}, "reply");
    if (pos_load_o) chk(exp_pos.size() ? exp_pos.pop_front() : 32'hx, pos_value_o, "preset");
    if (pos_report_o) begin
      reports = reports + 1;
      chk(position_i, pos_value_o, "report");
    end
    if (motion_stop_o) stops = stops + 1;
  end
  // Watchdog sized well above the few hundred cycles the tests need.
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    complete_run;
  end
  initial begin
    v = $urandom(32'h53db);
    position_i = $urandom;
    repeat (2) @(negedge clock_i);
    rst_n_i = 1'b1;
    chk(4'hf, main_out_o, "main_out");
    for (j = 0; j < 3; j = j + 1) begin
      v = $urandom;
      send(`MSQ_OP_STRING_REPLY, 0, 0, 0, {9'h0, {1'b0, v[1:0]} + 3'h1, v});
    end
    drain;
    multidrop_link_i = 1'b1;
    send(`MSQ_OP_STRING_REPLY, 0, 0, 0, {12'h4, v});
    idle(20);
    multidrop_link_i = 1'b0;
    $display("reply tests done");
    exp_pos.push_back(v);
    send(`MSQ_OP_POS_PRESET, 0, 0, 1, {12'h0, v});
    send(`MSQ_OP_POS_PRESET, 0, 0, 0, 44'h0);
    idle(10);
    chk(1, reports + exp_pos.size(), "reports");
    eo = 8'hff;
    mo = 4'hf;
    for (j = 0; j < 4; j = j + 1) begin
      v = $urandom % 4;
      if (j < 2) eo[v[2:0]] = j[0];
      else mo[v[1:0]] = j[0];
      send(`MSQ_OP_OUTPUT_DRIVE, 0, j[0] ? `MSQ_LET_H : `MSQ_LET_L, 0,
        {35'h0, j > 1, 5'h0, v[2:0]});
      idle(6);
      chk({mo, eo}, {main_out_o, exp_out_o}, "outputs");
    end
    main_out_general_i = 4'h0;
    send(`MSQ_OP_OUTPUT_DRIVE, 0, mo[0] ? `MSQ_LET_L : `MSQ_LET_H, 0, {35'h0, 1'b1, 8'h0});
    idle(6);
    chk(mo, main_out_o, "dedicated");
    main_out_general_i = 4'hf;
    $display("preset and output tests done");
    v = $urandom;
    jd = $urandom;
    send(`MSQ_OP_JOG_ACCEL, 0, 0, 0, {12'h0, v});
    idle(6);
    chk({v, v}, {jog_accel_o, jog_decel_o}, "jog rates");
    send(`MSQ_OP_JOG_DECEL, 0, 0, 0, {12'h0, jd});
    idle(6);
    chk(jd, jog_decel_o, "jog_decel");
    max_accel_setting_i = $urandom;
    decel_setting_i = $urandom;
    for (j = 0; j < 7; j = j + 1) begin
      t = tab[10 * j +: 10];
      kind_q = t[3:2];
      send(`MSQ_OP_MOTION, 0, 0, 0, {12'h0, $urandom});
      idle(6);
      send(t[9:6], 1, t[5:4], 0, 44'h0);
      chk({1'b1, t[1:0]}, {motion_stop_o, stop_decel_sel_o}, "stop");
      chk(t[0] ? decel_setting_i : t[1] ? jd : max_accel_setting_i, stop_decel_o, "rate");
      idle(4);
    end
    $display("halt tests done");
    send(`MSQ_OP_MOTION, 0, 0, 0, 44'h0);
    idle(6);
    keep = 1'b0;
    send(`MSQ_OP_STRING_REPLY, 0, 0, 0, 44'h1);
    send(`MSQ_OP_STRING_REPLY, 0, 0, 0, 44'h2);
    idle(2);
    chk(2, queue_count_o, "held");
    send(`MSQ_OP_HALT_FLUSH, 1, 0, 0, 44'h0);
    idle(2);
    chk(0, queue_count_o, "flushed");
    keep = 1'b1;
    send(`MSQ_OP_MOTION, 0, 0, 0, 44'h0);
    idle(6);
    wait_go = 1'b1;
    idle(1);
    wait_go = 1'b0;
    for (j = 0; j < 2; j = j + 1) send(`MSQ_OP_STRING_REPLY, 0, 0, 0, {12'h4, $urandom});
    send(`MSQ_OP_CURRENT_HALT, 1, 0, 0, 44'h0);
    idle(2);
    chk(0, wait_busy_i, "wait");
    drain;
    $display("queue tests done");
    multitask_enable_i = 1'b1;
    kind_q = `MSQ_MOVE_HOME;
    send(`MSQ_OP_MOTION, 0, 0, 0, 44'h0);
    idle(6);
    s0 = stops;
    send(`MSQ_OP_MOVE_HALT, 0, `MSQ_LET_D, 0, 44'h0);
    send(`MSQ_OP_STRING_REPLY, 0, 0, 0, {12'h4, $urandom});
    drain;
    chk({s0, 1'b1}, {stops, motion_busy_i}, "home kept");
    idle(60);
    kind_q = `MSQ_MOVE_FEED;
    send(`MSQ_OP_MOTION, 0, 0, 0, 44'h0);
    idle(6);
    wait_go = 1'b1;
    idle(1);
    wait_go = 1'b0;
    send(`MSQ_OP_MOVE_HALT, 0, `MSQ_LET_M, 0, 44'h0);
    idle(8);
    chk({s0 + 1, `MSQ_DSEL_MAX}, {stops, stop_decel_sel_o}, "move halt");
    chk(1, wait_busy_i, "wait kept");
    $display("move halt tests done");
    complete_run;
  end
endmodule // msq_stop_queue_bench
